// ### design/ccd_corr_regs.vh
`ifndef CCD_CORR_REGS_VH
`define CCD_CORR_REGS_VH
// Register indices.
`define REG_FIX_OFFSET 5'd6
`define REG_FIX_GAIN_LO 5'd7
`define REG_FIX_GAIN_HI 5'd8
`define REG_CORR_CTRL 5'd9
`define REG_TRA_WIDTH 5'd16
`define REG_TRB_WIDTH 5'd17
`define REG_TR_GUARD 5'd18
`define REG_RS_TIMING 5'd21
`define REG_SENSOR_MODE 5'd24
`define REG_SENSOR_DIS 5'd25
`define REG_POLARITY 5'd26
// Field positions.
`define CTRL_FIX_OFFSET_BIT 0
`define CTRL_FIX_GAIN_BIT 1
`define CTRL_RANGE_LO_BIT 2
`define CTRL_RANGE_HI_BIT 3
`define MODE_EVEN_ODD_BIT 0
`define MODE_TWO_TR_BIT 3
`define DIS_PHASE1_BIT 0
`define DIS_PHASE2_BIT 1
`define DIS_RS_BIT 2
`define DIS_TRA_BIT 3
`define DIS_TRB_BIT 4
`define DIS_COEF8_BIT 6
`define POL_PHASE_BIT 0
`define POL_RS_BIT 1
`define POL_TRA_BIT 2
`define POL_TRB_BIT 3
`define POL_PHASE_ALT_BIT 4
`define POL_READ_PHASE_BIT 5
// Reset value of every configuration register.
`define CFG_RESET 8'h00
// Timing: master clock period and the conversion divider.
`define MCLK_PERIOD_NS 5
`define PIX_DIV 4
`define PIX_PERIOD_NS (`MCLK_PERIOD_NS * `PIX_DIV)
`define PIX_CYCLES (`PIX_PERIOD_NS / `MCLK_PERIOD_NS)
`endif

// ### design/ccd_pixel_correction_interface.v
// Behaviour
// - Offset enable bit clear: subtract per-pixel bus offset from each ADC result.
// - Offset enable bit set: subtract fixed register 6 value, ignore the bus.
// - Offset operand is the low eight bus lines, 0 to 255.
// - Gain bit clear: multiply corrected pixel by per-pixel bus gain coefficient.
// - Gain bit set: use fixed coefficient from registers 7 and 8.
// - Ten-bit mode gain is one plus coefficient over 2048, 1024 or 512.
// - Register 25 bit 6 selects 8-bit coefficients, N 512, 256 or 128.
// - Register 9 bits 3,2 pick range: 1,0 is 1.5; 0,1 is 2.0; 0,0 is 3.0.
// - Registers 16-18 set transfer widths and guard; register 24 bit 3 adds pulse b.
// - Register 26 bits 2,3 set transfer polarities; register 25 bits 3,4 suppress.
// - Register 21 sets reset pulse width and place; 26 bit 1 polarity; 25 bit 2 off.
// - Second shift clock phase is the inverse of the first unless either phase is disabled.
// - Register 24 bit 0: pixel-rate standard mode or half-rate even/odd mode.
// - Register 26 bits 0 and 4 both set phase polarity; 25 bits 0,1 disable phases.
// - Configuration write is address transfer then data transfer, stored at address.
// - Configuration writes are accepted whatever the line-active level.
// - Fetch strobe low drives the bus even with chip select high.
// - Read phase bit 0: pixels change before conversion strobe fall; 1: before rise.
// - Outside a register read, pixel bus drives only with line-active high and pixel enable low.
// - Conversion and output rate is one quarter of the master clock.
`timescale 1ns/1ps
`include "ccd_corr_regs.vh"
module ccd_pixel_correction_interface (
  input wire ref_clk,
  input wire reset_n,
  input wire [9:0] adc_result,
  input wire [9:0] correction_bus,
  input wire line_active,
  input wire cs_n,
  input wire wr_n,
  input wire rd_n,
  input wire pixel_rd_n,
  input wire [9:0] pixel_io_bus_in,
  output wire [9:0] pixel_io_bus_out,
  output wire pixel_io_bus_oe,
  output reg conv_done,
  output reg shift_clk_1,
  output reg shift_clk_2,
  output reg sensor_reset_pulse,
  output reg transfer_pulse_a,
  output reg transfer_pulse_b
);
  localparam integer PIX_DIV_LAST = `PIX_CYCLES - 1;
  localparam [1:0] PIX_DIV_MAX = PIX_DIV_LAST[1:0];
  localparam [2:0] TR_IDLE = 3'd0;
  localparam [2:0] TR_GUARD1 = 3'd1;
  localparam [2:0] TR_PULSE_A = 3'd2;
  localparam [2:0] TR_GUARD2 = 3'd3;
  localparam [2:0] TR_PULSE_B = 3'd4;
  localparam [2:0] TR_GUARD3 = 3'd5;

  // Shift amount giving N = 2**shift for the selected range and coefficient width.
  function [3:0] gain_shift;
    input [1:0] range;
    input coef8;
    reg [3:0] base;
    begin
      case (range)
        2'b10: base = 4'd11;
        2'b01: base = 4'd10;
        2'b00: base = 4'd9;
        default: base = 4'd11;
      endcase
      gain_shift = coef8 ? (base - 4'd2) : base;
    end
  endfunction

  // Saturate an extended result to the 10-bit output range.
  function [9:0] sat10;
    input [11:0] value;
    begin
      sat10 = (value[11:10] != 2'b00) ? 10'h3ff : value[9:0];
    end
  endfunction

  reg [7:0] cfg_mem [0:31];
  reg [4:0] addr_reg;
  reg addr_loaded_reg;
  reg wr_n_d_reg;
  reg rd_n_d_reg;
  reg [1:0] phase_reg;
  reg [9:0] diff_reg;
  reg [9:0] coef_reg;
  reg diff_valid_reg;
  reg [9:0] result_reg;
  reg result_valid_reg;
  reg [9:0] pixel_out_reg;
  reg phi_reg;
  reg line_d_reg;
  reg [2:0] tr_state_reg;
  reg [2:0] tr_state_next;
  reg [7:0] tr_count_reg;
  reg [7:0] tr_width;
  integer i;

  wire pix_en;
  wire [7:0] ctrl;
  wire [7:0] mode;
  wire [7:0] dis;
  wire [7:0] pol;
  wire [7:0] offset_operand;
  wire [9:0] gain_coef;
  wire [3:0] shift;
  wire [19:0] product;
  wire [19:0] scaled;
  wire [11:0] gained;
  wire [9:0] fifo_data;
  wire fifo_valid;
  wire fifo_in_ready;
  wire out_strobe;
  wire phase_pol;
  wire [1:0] rs_start;
  wire [1:0] rs_len;
  wire [1:0] rs_rel;
  wire rs_active;
  wire tr_start;

  assign ctrl = cfg_mem[`REG_CORR_CTRL];
  assign mode = cfg_mem[`REG_SENSOR_MODE];
  assign dis = cfg_mem[`REG_SENSOR_DIS];
  assign pol = cfg_mem[`REG_POLARITY];

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration port.

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      wr_n_d_reg <= 1'b1;
      rd_n_d_reg <= 1'b1;
      addr_reg <= 5'd0;
      addr_loaded_reg <= 1'b0;
      for (i = 0; i < 32; i = i + 1) begin
        cfg_mem[i] <= `CFG_RESET;
      end
    end else begin
      wr_n_d_reg <= wr_n;
      rd_n_d_reg <= rd_n;
      // A write completes on the rising edge of the write strobe, with no regard to line_active.
      if (!wr_n_d_reg && wr_n && !cs_n) begin
        if (!addr_loaded_reg) begin
          addr_reg <= pixel_io_bus_in[4:0];
          addr_loaded_reg <= 1'b1;
        end else begin
          cfg_mem[addr_reg] <= pixel_io_bus_in[7:0];
          addr_loaded_reg <= 1'b0;
        end
      end else if (!rd_n_d_reg && rd_n && !cs_n) begin
        addr_loaded_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pixel timing: one conversion every four master clocks.

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      phase_reg <= 2'd0;
      conv_done <= 1'b1;
    end else begin
      phase_reg <= (phase_reg == PIX_DIV_MAX) ? 2'd0 : phase_reg + 2'd1;
      conv_done <= (phase_reg == PIX_DIV_MAX) | (phase_reg == 2'd0);
    end
  end
  assign pix_en = (phase_reg == 2'd0);

  ////////////////////////////////////////////////////////////////////////////////
  // Correction datapath: subtract, then shade.

  assign offset_operand = ctrl[`CTRL_FIX_OFFSET_BIT] ? cfg_mem[`REG_FIX_OFFSET]
                                                     : correction_bus[7:0];
  assign gain_coef = ctrl[`CTRL_FIX_GAIN_BIT] ?
                     {cfg_mem[`REG_FIX_GAIN_HI][1:0], cfg_mem[`REG_FIX_GAIN_LO]} :
                     (dis[`DIS_COEF8_BIT] ? {2'b00, correction_bus[7:0]} : correction_bus);
  assign shift = gain_shift({ctrl[`CTRL_RANGE_HI_BIT], ctrl[`CTRL_RANGE_LO_BIT]}, dis[`DIS_COEF8_BIT]);
  assign product = diff_reg * coef_reg;
  assign scaled = product >> shift;
  // Gain = 1 + coef/N, computed as x + (x*coef >> log2 N) so no divider is needed.
  // A ten-bit fixed gain in eight-bit mode can overflow twelve bits, so any high bit forces saturation.
  assign gained = (scaled[19:11] != 9'h000) ? 12'hfff : ({2'b00, diff_reg} + {1'b0, scaled[10:0]});

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      diff_reg <= 10'h000;
      coef_reg <= 10'h000;
      diff_valid_reg <= 1'b0;
      result_reg <= 10'h000;
      result_valid_reg <= 1'b0;
    end else begin
      if (pix_en) begin
        // A negative difference would wrap to a bright pixel, so it stops at black.
        diff_reg <= (adc_result > {2'b00, offset_operand}) ?
                    (adc_result - {2'b00, offset_operand}) : 10'h000;
        coef_reg <= gain_coef;
        diff_valid_reg <= 1'b1;
      end else if (diff_valid_reg && (!result_valid_reg || fifo_in_ready)) begin
        result_reg <= sat10(gained);
        result_valid_reg <= 1'b1;
        diff_valid_reg <= 1'b0;
      end else if (result_valid_reg && fifo_in_ready) begin
        result_valid_reg <= 1'b0;
      end
    end
  end

  pixel_skid_buffer u_buffer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .in_data(result_reg),
    .in_valid(result_valid_reg),
    .in_ready(fifo_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(out_strobe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Pixel output register and shared bus.

  // The output updates in the clock before the chosen conversion strobe edge.
  assign out_strobe = line_active &
                      (pol[`POL_READ_PHASE_BIT] ? (phase_reg == 2'd2) : (phase_reg == 2'd0));

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      pixel_out_reg <= 10'h000;
    end else if (out_strobe && fifo_valid) begin
      pixel_out_reg <= fifo_data;
    end
  end

  // A configuration read drives the bus even with chip select high.
  assign pixel_io_bus_oe = ~rd_n | (line_active & ~pixel_rd_n);
  assign pixel_io_bus_out = !rd_n ? {2'b00, cfg_mem[addr_reg]} : pixel_out_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Shift clock phases and sensor reset pulse.

  assign phase_pol = pol[`POL_PHASE_BIT] | pol[`POL_PHASE_ALT_BIT];
  assign rs_start = cfg_mem[`REG_RS_TIMING][1:0];
  assign rs_len = cfg_mem[`REG_RS_TIMING][3:2];
  // Position counts from the falling shift clock edge, which lands on phase 2.
  assign rs_rel = phase_reg - 2'd2 - rs_start;
  assign rs_active = (rs_rel <= rs_len);

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      phi_reg <= 1'b1;
      shift_clk_1 <= 1'b0;
      shift_clk_2 <= 1'b0;
      sensor_reset_pulse <= 1'b0;
    end else begin
      if (mode[`MODE_EVEN_ODD_BIT]) begin
        if (phase_reg == 2'd2) begin
          phi_reg <= ~phi_reg;
        end
      end else begin
        phi_reg <= (phase_reg == PIX_DIV_MAX) | (phase_reg == 2'd0);
      end
      shift_clk_1 <= ~dis[`DIS_PHASE1_BIT] & (phi_reg ^ phase_pol);
      shift_clk_2 <= ~dis[`DIS_PHASE2_BIT] & ~(phi_reg ^ phase_pol);
      sensor_reset_pulse <= dis[`DIS_RS_BIT] ? pol[`POL_RS_BIT] : (rs_active ^ pol[`POL_RS_BIT]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer pulse sequencer, started by a rising edge of line_active while idle.

  assign tr_start = line_active & ~line_d_reg;

  always @* begin
    case (tr_state_reg)
      TR_GUARD1: tr_width = cfg_mem[`REG_TR_GUARD];
      TR_PULSE_A: tr_width = cfg_mem[`REG_TRA_WIDTH];
      TR_GUARD2: tr_width = cfg_mem[`REG_TR_GUARD];
      TR_PULSE_B: tr_width = cfg_mem[`REG_TRB_WIDTH];
      TR_GUARD3: tr_width = cfg_mem[`REG_TR_GUARD];
      default: tr_width = 8'h00;
    endcase
  end

  always @* begin
    tr_state_next = tr_state_reg;
    case (tr_state_reg)
      TR_IDLE: begin
        if (tr_start) begin
          tr_state_next = TR_GUARD1;
        end
      end
      TR_GUARD1: tr_state_next = TR_PULSE_A;
      TR_PULSE_A: tr_state_next = TR_GUARD2;
      TR_GUARD2: tr_state_next = mode[`MODE_TWO_TR_BIT] ? TR_PULSE_B : TR_IDLE;
      TR_PULSE_B: tr_state_next = TR_GUARD3;
      TR_GUARD3: tr_state_next = TR_IDLE;
      default: tr_state_next = TR_IDLE;
    endcase
  end

  // Widths count pixel periods; a width of zero still lasts one period.
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      line_d_reg <= 1'b0;
      tr_state_reg <= TR_IDLE;
      tr_count_reg <= 8'h00;
      transfer_pulse_a <= 1'b0;
      transfer_pulse_b <= 1'b0;
    end else begin
      line_d_reg <= line_active;
      if (tr_state_reg == TR_IDLE) begin
        tr_state_reg <= tr_state_next;
        tr_count_reg <= 8'h00;
      end else if (pix_en) begin
        if (tr_count_reg >= tr_width) begin
          tr_state_reg <= tr_state_next;
          tr_count_reg <= 8'h00;
        end else begin
          tr_count_reg <= tr_count_reg + 8'h01;
        end
      end
      transfer_pulse_a <= ((tr_state_reg == TR_PULSE_A) & ~dis[`DIS_TRA_BIT]) ^ pol[`POL_TRA_BIT];
      transfer_pulse_b <= ((tr_state_reg == TR_PULSE_B) & ~dis[`DIS_TRB_BIT]) ^ pol[`POL_TRB_BIT];
    end
  end
endmodule // ccd_pixel_correction_interface

// ### design/pixel_skid_buffer.v
`timescale 1ns/1ps
`include "ccd_corr_regs.vh"
module pixel_skid_buffer (
  input wire ref_clk,
  input wire reset_n,
  input wire [9:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [9:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [9:0] mem_reg [0:1];
  reg wr_ptr_reg;
  reg rd_ptr_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = (count_reg != 2'd2);
  assign out_valid = (count_reg != 2'd0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'd0;
      mem_reg[0] <= 10'h000;
      mem_reg[1] <= 10'h000;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'd1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'd1;
      end
    end
  end
endmodule // pixel_skid_buffer

// ### verification/ccd_pixel_correction_interface_props.sv
`timescale 1ns/1ps
module ccd_corr_checker (
  input wire ref_clk,
  input wire reset_n,
  input wire line_active,
  input wire rd_n,
  input wire pixel_rd_n,
  input wire [9:0] pixel_io_bus_out,
  input wire pixel_io_bus_oe,
  input wire conv_done,
  input wire shift_clk_1,
  input wire shift_clk_2,
  input wire sensor_reset_pulse,
  input wire transfer_pulse_a,
  input wire transfer_pulse_b
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  property p_oe;
    pixel_io_bus_oe == (!rd_n || (line_active && !pixel_rd_n));
  endproperty
  a_oe: assert property (p_oe) else $error("bus enable mismatch");
  property p_period;
    $fell(conv_done) |=> !conv_done ##1 conv_done ##1 conv_done ##1 !conv_done;
  endproperty
  a_period: assert property (p_period) else $error("strobe period wrong");
  property p_high;
    $rose(conv_done) |=> conv_done ##1 !conv_done;
  endproperty
  a_high: assert property (p_high) else $error("strobe high time wrong");
  property p_excl;
    !(shift_clk_1 && shift_clk_2);
  endproperty
  a_excl: assert property (p_excl) else $error("both phases high");
  property p_rdout;
    !rd_n |-> pixel_io_bus_oe && pixel_io_bus_out[9:8] == 2'b00;
  endproperty
  a_rdout: assert property (p_rdout) else $error("register read not driven");
  // Two samples of idle line are checked, though the output strobe gates on line_active directly, unregistered.
  property p_hold;
    rd_n && $past(rd_n) && !$past(line_active) && !$past(line_active, 2) |-> $stable(pixel_io_bus_out);
  endproperty
  a_hold: assert property (p_hold) else $error("pixel moved with line idle");
  property p_rate;
    rd_n && $past(rd_n) && $changed(pixel_io_bus_out) |=> (!rd_n || $stable(pixel_io_bus_out)) [*3];
  endproperty
  a_rate: assert property (p_rate) else $error("pixel changed too soon");
  property p_rst;
    !$past(reset_n) |-> conv_done && !shift_clk_1 && !shift_clk_2 && !sensor_reset_pulse
      && !transfer_pulse_a && !transfer_pulse_b;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset level");
endmodule // ccd_corr_checker

bind ccd_pixel_correction_interface ccd_corr_checker chk_u (.ref_clk(ref_clk), .reset_n(reset_n),
  .line_active(line_active), .rd_n(rd_n), .pixel_rd_n(pixel_rd_n), .pixel_io_bus_out(pixel_io_bus_out),
  .pixel_io_bus_oe(pixel_io_bus_oe), .conv_done(conv_done), .shift_clk_1(shift_clk_1),
  .shift_clk_2(shift_clk_2), .sensor_reset_pulse(sensor_reset_pulse),
  .transfer_pulse_a(transfer_pulse_a), .transfer_pulse_b(transfer_pulse_b));

// ### verification/scan_ctrl_model.sv
`timescale 1ns/1ps
module scan_ctrl_model (
  input wire ref_clk,
  input wire conv_done,
  input wire cs_n,
  input wire [9:0] coef_word,
  output reg [9:0] correction_bus,
  output wire pixel_rd_n
);
  // Tying the pixel enable to the strobe leaves the shared bus free for coefficients half of each pixel.
  // The enable is parked while the controller owns the shared bus for a configuration transfer.
  assign pixel_rd_n = conv_done | ~cs_n;
  always @(posedge ref_clk) begin
    correction_bus <= coef_word;
  end
endmodule // scan_ctrl_model

// ### verification/tb_ccd_pixel_correction_interface.sv
`timescale 1ns/1ps
module tb_ccd_pixel_correction_interface;
  reg ref_clk = 1'b0;
  reg reset_n = 1'b0;
  reg [9:0] adc = 10'h000;
  reg [9:0] coef = 10'h000;
  reg line = 1'b0;
  reg cs_n = 1'b1;
  reg wr_n = 1'b1;
  reg rd_n = 1'b1;
  reg [9:0] drv = 10'h000;
  reg base = 1'b0;
  wire [9:0] cbus, bus_in, bus_out;
  wire prd_n, oe, cd, sc1, sc2, rs, tra, trb;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  // After each write a released bus shows the inverse of the last driven level rather than a stale copy.
  assign bus_in = oe ? bus_out : drv;
  scan_ctrl_model part_u (.ref_clk(ref_clk), .conv_done(cd), .cs_n(cs_n), .coef_word(coef),
    .correction_bus(cbus), .pixel_rd_n(prd_n));
  ccd_pixel_correction_interface dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .adc_result(adc),
    .correction_bus(cbus), .line_active(line), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .pixel_rd_n(prd_n),
    .pixel_io_bus_in(bus_in), .pixel_io_bus_out(bus_out), .pixel_io_bus_oe(oe), .conv_done(cd),
    .shift_clk_1(sc1), .shift_clk_2(sc2), .sensor_reset_pulse(rs), .transfer_pulse_a(tra),
    .transfer_pulse_b(trb));
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      fail_count = fail_count + 1;
      give_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic xfer(input logic [9:0] v, input logic c);
    cs_n = c;
    drv = v;
    wr_n = 1'b0;
    tick(1);
    wr_n = 1'b1;
    tick(2);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic c = 1'b0);
    xfer({5'h00, a}, c);
    xfer({2'b00, d}, c);
    cs_n = 1'b1;
    drv = ~drv;
    tick(1);
  endtask
  ////////////////////////////////////////
  task automatic t_cfg;
    logic [9:0] v;
    line = 1'b1;
    wr(5'h06, 8'h5a);
    wr(5'h06, 8'hff, 1'b1);
    line = 1'b0;
    tick(4);
    xfer(10'h006, 1'b0);
    rd_n = 1'b0;
    tick(1);
    v = bus_in;
    chk(oe, 1'b1, "read drive");
    rd_n = 1'b1;
    tick(1);
    cs_n = 1'b1;
    chk(v, 10'h05a, "cfg read");
    $display("t_cfg done");
  endtask
  task automatic t_pix(input logic [7:0] r6, r7, r8, r9, r25, input logic [9:0] a, c, exp);
    wr(5'h06, r6);
    wr(5'h07, r7);
    wr(5'h08, r8);
    wr(5'h09, r9);
    wr(5'h19, r25);
    adc = a;
    coef = c;
    line = 1'b1;
    tick(100);
    chk(bus_out, exp, "pixel");
    line = 1'b0;
    tick(8);
    $display("t_pix done");
  endtask
  task automatic t_phase(input logic ph);
    int n;
    logic [9:0] p;
    n = 0;
    wr(5'h1a, {2'b00, ph, 5'h00});
    coef = 10'h000;
    adc = 10'h064;
    line = 1'b1;
    tick(40);
    repeat (40) begin
      p = bus_out;
      adc = adc + 10'h001;
      tick(1);
      if (bus_out !== p) begin
        n = n + 1;
        tick(1);
        chk(cd, ph, "read phase");
      end
    end
    line = 1'b0;
    chk(n > 7, 1'b1, "pixel count");
    $display("t_phase done");
  endtask
  task automatic t_clk(input logic [7:0] r24, r25, r26, input int nt);
    int n;
    int nr;
    logic p;
    logic q;
    n = 0;
    nr = 0;
    wr(5'h18, r24);
    wr(5'h19, r25);
    wr(5'h1a, r26);
    @(negedge cd);
    #1;
    if (r26 == 8'h00) base = sc1;
    else if (r25 == 8'h00) chk(sc1, {~base}, "phase pol");
    repeat (32) begin
      p = sc1;
      q = rs;
      tick(1);
      n = n + (sc1 !== p);
      nr = nr + (rs !== q);
      if (r25[0]) chk({sc1, sc2, rs}, {2'b00, r26[1]}, "clk off");
      else chk(sc2, {~sc1}, "phase inv");
    end
    chk(n, nt, "toggles");
    chk(nr, r25[2] ? 0 : 16, "reset toggles");
    $display("t_clk done");
  endtask
  task automatic t_tr(input logic [7:0] r24, r25, r26, input logic ea, eb);
    int na;
    int nb;
    na = 0;
    nb = 0;
    wr(5'h18, r24);
    wr(5'h19, r25);
    wr(5'h1a, r26);
    tick(4);
    chk({tra, trb}, {r26[2], r26[3]}, "tr idle");
    line = 1'b1;
    repeat (120) begin
      tick(1);
      na = na + (tra !== r26[2]);
      nb = nb + (trb !== r26[3]);
    end
    line = 1'b0;
    tick(4);
    chk({na > 0, nb > 0}, {ea, eb}, "tr pulses");
    $display("t_tr done");
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    tick(2);
    t_cfg();
    t_pix(8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 10'h1f4, 10'h3c8, 10'h1b9);
    t_pix(8'h32, 8'h00, 8'h02, 8'h07, 8'h00, 10'h12c, 10'h3ff, 10'h177);
    t_pix(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 10'h064, 10'h0c8, 10'h000);
    t_pix(8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 10'h190, 10'h380, 10'h220);
    t_pix(8'h00, 8'h00, 8'h00, 8'h04, 8'h40, 10'h190, 10'h040, 10'h1a4);
    t_pix(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 10'h3e8, 10'h3ff, 10'h3ff);
    t_phase(1'b0);
    t_phase(1'b1);
    t_clk(8'h00, 8'h00, 8'h00, 16);
    t_clk(8'h00, 8'h00, 8'h10, 16);
    t_clk(8'h00, 8'h00, 8'h01, 16);
    t_clk(8'h01, 8'h00, 8'h00, 8);
    t_clk(8'h00, 8'h07, 8'h02, 0);
    wr(5'h10, 8'h01);
    wr(5'h11, 8'h01);
    wr(5'h12, 8'h00);
    t_tr(8'h08, 8'h00, 8'h00, 1'b1, 1'b1);
    t_tr(8'h00, 8'h00, 8'h00, 1'b1, 1'b0);
    t_tr(8'h08, 8'h10, 8'h0c, 1'b1, 1'b0);
    t_tr(8'h08, 8'h08, 8'h00, 1'b0, 1'b1);
    give_verdict();
  end
endmodule // tb_ccd_pixel_correction_interface
